// ==== design/fnp_defs.svh ====
// Purpose: Offsets, field positions and reset values of the nibble I/O ports
// Assumes: Data memory and register file both use 7-bit nibble addresses
// Notes:   Included by bare name; definitions only
//
// What this block does
// - First port: nibble latch at 70H.
// - First port direction bits at 35H, 1=output.
// - First port direction and latch reset to zero.
// - Write loads latch; read mixes pins and latch.
// - Second port at 71H, group direction 24H.
// - Second port direction and latch reset zero.
// - Second port read: pins or latch by group.
// - Third port at 72H, direction bits 34H.
// - Third port mixed read; resets to zero.
// - First three ports drive high and low.
// - Fourth port 73H, open drain, bits 33H.
// - Fourth port resets zero; direction keeps latch.
// - Serial enable makes pins 0-2 serial.
// - Timer select makes pin 3 timer output.
// - Timer output presents one at timer reset.
// - Timer output inverts on every count match without a timer reset in the same cycle.
// - Serial clock read: latch internal, pin external.
// - Serial out reads latch, input pin, timer latch.
`ifndef FNP_DEFS_SVH
`define FNP_DEFS_SVH

// ----------------------------------------
// Data memory, bank zero
// ----------------------------------------
`define FNP_BANK_ZERO   4'h0
`define FNP_DM_FIRST    7'h70
`define FNP_DM_SECOND   7'h71
`define FNP_DM_THIRD    7'h72
`define FNP_DM_FOURTH   7'h73

// ----------------------------------------
// Register file control addresses
// ----------------------------------------
`define FNP_RF_SIO_EN   7'h0a
`define FNP_RF_TMO_SEL  7'h12
`define FNP_RF_DIR_B    7'h24
`define FNP_RF_DIR_D    7'h33
`define FNP_RF_DIR_C    7'h34
`define FNP_RF_DIR_A    7'h35
`define FNP_FLAG_BIT    0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FNP_RST_NIB     4'h0
`define FNP_RST_BIT     1'b0
`define FNP_RST_TMO     1'b1

`endif

// ==== design/fnp_pkg.sv ====
// Purpose: Types shared by the nibble I/O port design
// Assumes: Four ports of four bits each
// Notes:   Offsets and reset values live in fnp_defs.svh
package fnp_pkg;

  // ----------------------------------------
  // Basic types
  // ----------------------------------------
  typedef logic [3:0] fnp_nib_t;          // One data nibble

  // ----------------------------------------
  // Whole state of the port block
  // ----------------------------------------
  typedef struct packed {
    fnp_nib_t dir_a;                      // Per-pin direction, first port
    logic     dir_b;                      // Group direction, second port
    fnp_nib_t dir_c;                      // Per-pin direction, third port
    fnp_nib_t dir_d;                      // Per-pin direction, fourth port
    logic     sio_en;                     // Serial pin enable
    logic     tmo_sel;                    // Timer output select
    fnp_nib_t lat_a;                      // Output latches
    fnp_nib_t lat_b;
    fnp_nib_t lat_c;
    fnp_nib_t lat_d;
    logic     tmo;                        // Timer match output flop
    fnp_nib_t dm_rdata;                   // Data memory read answer
    fnp_nib_t rf_rdata;                   // Register file read answer
    fnp_nib_t a_o;                        // Registered pin drive
    fnp_nib_t a_oe;
    fnp_nib_t b_o;
    fnp_nib_t b_oe;
    fnp_nib_t c_o;
    fnp_nib_t c_oe;
    fnp_nib_t d_o;
    fnp_nib_t d_oe;
  } fnp_state_t;

endpackage

// ==== design/fnp_sync.sv ====
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Only the second stage leaves the module
`timescale 1ns/10ps
module fnp_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  import fnp_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;                     // Metastable stage, read by s2 only
    logic [W-1:0] s2;                     // Settled stage
  } fnp_sync_t;

  fnp_sync_t q;
  fnp_sync_t next_q;

  // Shift one stage per clock
  always_comb begin
    next_q    = q;
    next_q.s1 = d_i;
    next_q.s2 = q.s1;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q.s2;
endmodule

// ==== design/fnp_rdsel.sv ====
// Purpose: Per-bit read select between output latch and pin level
// Assumes: Pin levels are already synchronised
// Notes:   Pure combinational; the caller registers the result
`timescale 1ns/10ps
module fnp_rdsel #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] sel_latch_i,
  input  wire logic [W-1:0] latch_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] rdata_o
);
  import fnp_pkg::*;

  // Latch where selected, pin level elsewhere
  always_comb begin
    rdata_o = (sel_latch_i & latch_i) | (~sel_latch_i & pin_i);
  end
endmodule

// ==== design/fnp_ports.sv ====
// Purpose: Four nibble I/O ports with latches and direction control
// Assumes: One CPU clock; pins arrive asynchronously
// Notes:   Read answers appear one clock after the read strobe
`timescale 1ns/10ps
`include "fnp_defs.svh"
module fnp_ports (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic [3:0]    dm_bank_i,
  input  wire logic [6:0]    dm_addr_i,
  input  wire logic          dm_wr_i,
  input  wire logic          dm_rd_i,
  input  wire fnp_pkg::fnp_nib_t dm_wdata_i,
  output fnp_pkg::fnp_nib_t  dm_rdata_o,
  input  wire logic [6:0]    rf_addr_i,
  input  wire logic          rf_wr_i,
  input  wire logic          rf_rd_i,
  input  wire fnp_pkg::fnp_nib_t rf_wdata_i,
  output fnp_pkg::fnp_nib_t  rf_rdata_o,
  input  wire fnp_pkg::fnp_nib_t first_port_i,
  output fnp_pkg::fnp_nib_t  first_port_o,
  output fnp_pkg::fnp_nib_t  first_port_oe_o,
  input  wire fnp_pkg::fnp_nib_t second_port_i,
  output fnp_pkg::fnp_nib_t  second_port_o,
  output fnp_pkg::fnp_nib_t  second_port_oe_o,
  input  wire fnp_pkg::fnp_nib_t third_port_i,
  output fnp_pkg::fnp_nib_t  third_port_o,
  output fnp_pkg::fnp_nib_t  third_port_oe_o,
  input  wire fnp_pkg::fnp_nib_t fourth_port_i,
  output fnp_pkg::fnp_nib_t  fourth_port_o,
  output fnp_pkg::fnp_nib_t  fourth_port_oe_o,
  input  wire logic          sio_int_clk_i,
  input  wire logic          sio_sck_out_i,
  input  wire logic          sio_so_i,
  output logic               sio_sck_in_o,
  output logic               sio_si_o,
  input  wire logic          timer_reset_i,
  input  wire logic          timer_match_i,
  output logic               timer_match_pin_o
);
  import fnp_pkg::*;

  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  fnp_state_t q;                          // Registered state
  fnp_state_t next_q;                     // Next state
  logic [15:0] pins_s;                    // Synchronised pins, d:c:b:a
  logic [3:0][3:0] mix_sel;               // 1 = read latch for that bit
  logic [3:0][3:0] mix_lat;
  logic [3:0][3:0] mix_pin;
  logic [3:0][3:0] mix_rd;                // Read value per port
  fnp_nib_t d_sel;                        // Fourth port read select
  fnp_nib_t d_pull;                       // Fourth port pull-low request

  // Bank zero data memory hit at a port offset
  function automatic logic dm_at(input logic [6:0] off);
    dm_at = (dm_bank_i == `FNP_BANK_ZERO) && (dm_addr_i == off);
  endfunction

  // Register file hit at a control offset
  function automatic logic rf_at(input logic [6:0] off);
    rf_at = (rf_addr_i == off);
  endfunction

  // Timer output flop next value; reset beats a match in the same cycle
  // Kept as a function so the pin drive never reads next_q back
  function automatic logic tmo_next(input logic cur);
    tmo_next = timer_reset_i ? 1'b1 : (timer_match_i ? ~cur : cur);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins are external, so every read path goes through two flops
  fnp_sync #(
    .W (16)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({fourth_port_i, third_port_i, second_port_i, first_port_i}),
    .q_o     (pins_s)
  );

  // ----------------------------------------
  // Read selection per port
  // ----------------------------------------
  // Fourth port read select depends on the pin function
  always_comb begin
    d_sel = q.dir_d;
    if (q.sio_en) begin
      d_sel[0] = sio_int_clk_i;
      d_sel[1] = 1'b1;
      d_sel[2] = 1'b0;
    end
    if (q.tmo_sel) begin
      d_sel[3] = 1'b1;
    end
  end

  // Gather inputs of the four read selectors
  always_comb begin
    mix_sel[0] = q.dir_a;
    mix_sel[1] = {4{q.dir_b}};
    mix_sel[2] = q.dir_c;
    mix_sel[3] = d_sel;
    mix_lat[0] = q.lat_a;
    mix_lat[1] = q.lat_b;
    mix_lat[2] = q.lat_c;
    mix_lat[3] = q.lat_d;
    mix_pin[0] = pins_s[3:0];
    mix_pin[1] = pins_s[7:4];
    mix_pin[2] = pins_s[11:8];
    mix_pin[3] = pins_s[15:12];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rd
      fnp_rdsel #(
        .W (4)
      ) u_rdsel (
        .sel_latch_i (mix_sel[gi]),
        .latch_i     (mix_lat[gi]),
        .pin_i       (mix_pin[gi]),
        .rdata_o     (mix_rd[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Fourth port open-drain requests
  // ----------------------------------------
  // Open drain can only pull low, so a latch 1 means release
  always_comb begin
    d_pull = q.dir_d & ~q.lat_d;
    if (q.sio_en) begin
      d_pull[0] = sio_int_clk_i & ~sio_sck_out_i;
      d_pull[1] = ~sio_so_i;
      d_pull[2] = 1'b0;
    end
    if (q.tmo_sel) begin
      d_pull[3] = ~tmo_next(q.tmo);
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_q = q;
    // Data memory writes land in the latch in any direction
    if (dm_wr_i) begin
      if (dm_at(`FNP_DM_FIRST)) begin
        next_q.lat_a = dm_wdata_i;
      end
      if (dm_at(`FNP_DM_SECOND)) begin
        next_q.lat_b = dm_wdata_i;
      end
      if (dm_at(`FNP_DM_THIRD)) begin
        next_q.lat_c = dm_wdata_i;
      end
      if (dm_at(`FNP_DM_FOURTH)) begin
        next_q.lat_d = dm_wdata_i;
      end
    end
    // Register file writes; direction never touches a latch
    if (rf_wr_i) begin
      case (rf_addr_i)
        `FNP_RF_DIR_A: begin
          next_q.dir_a = rf_wdata_i;
        end
        `FNP_RF_DIR_B: begin
          next_q.dir_b = rf_wdata_i[`FNP_FLAG_BIT];
        end
        `FNP_RF_DIR_C: begin
          next_q.dir_c = rf_wdata_i;
        end
        `FNP_RF_DIR_D: begin
          next_q.dir_d = rf_wdata_i;
        end
        `FNP_RF_SIO_EN: begin
          next_q.sio_en = rf_wdata_i[`FNP_FLAG_BIT];
        end
        `FNP_RF_TMO_SEL: begin
          next_q.tmo_sel = rf_wdata_i[`FNP_FLAG_BIT];
        end
        default: begin
          // Other peripherals own these addresses
        end
      endcase
    end
    // Timer output flop: one on timer reset, inverted on a match
    next_q.tmo = tmo_next(q.tmo);
    // Data memory read answer, held until the next read
    if (dm_rd_i) begin
      next_q.dm_rdata = '0;
      if (dm_at(`FNP_DM_FIRST)) begin
        next_q.dm_rdata = mix_rd[0];
      end
      if (dm_at(`FNP_DM_SECOND)) begin
        next_q.dm_rdata = mix_rd[1];
      end
      if (dm_at(`FNP_DM_THIRD)) begin
        next_q.dm_rdata = mix_rd[2];
      end
      if (dm_at(`FNP_DM_FOURTH)) begin
        next_q.dm_rdata = mix_rd[3];
      end
    end
    // Register file read answer; unused upper bits read zero
    if (rf_rd_i) begin
      case (rf_addr_i)
        `FNP_RF_DIR_A:   next_q.rf_rdata = q.dir_a;
        `FNP_RF_DIR_B:   next_q.rf_rdata = {3'h0, q.dir_b};
        `FNP_RF_DIR_C:   next_q.rf_rdata = q.dir_c;
        `FNP_RF_DIR_D:   next_q.rf_rdata = q.dir_d;
        `FNP_RF_SIO_EN:  next_q.rf_rdata = {3'h0, q.sio_en};
        `FNP_RF_TMO_SEL: next_q.rf_rdata = {3'h0, q.tmo_sel};
        default:         next_q.rf_rdata = 4'h0;
      endcase
    end
    // Pin drive; push-pull ports drive both levels when enabled
    next_q.a_o  = q.lat_a;
    next_q.a_oe = q.dir_a;
    next_q.b_o  = q.lat_b;
    next_q.b_oe = {4{q.dir_b}};
    next_q.c_o  = q.lat_c;
    next_q.c_oe = q.dir_c;
    next_q.d_o  = 4'h0;
    next_q.d_oe = d_pull;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q         <= '0;
      q.dir_a   <= `FNP_RST_NIB;
      q.lat_a   <= `FNP_RST_NIB;
      q.dir_b   <= `FNP_RST_BIT;
      q.lat_b   <= `FNP_RST_NIB;
      q.dir_c   <= `FNP_RST_NIB;
      q.lat_c   <= `FNP_RST_NIB;
      q.dir_d   <= `FNP_RST_NIB;
      q.lat_d   <= `FNP_RST_NIB;
      q.sio_en  <= `FNP_RST_BIT;
      q.tmo_sel <= `FNP_RST_BIT;
      q.tmo     <= `FNP_RST_TMO;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------
  // Outputs, all from flops
  // ----------------------------------------
  assign dm_rdata_o        = q.dm_rdata;
  assign rf_rdata_o        = q.rf_rdata;
  assign first_port_o      = q.a_o;
  assign first_port_oe_o   = q.a_oe;
  assign second_port_o     = q.b_o;
  assign second_port_oe_o  = q.b_oe;
  assign third_port_o      = q.c_o;
  assign third_port_oe_o   = q.c_oe;
  assign fourth_port_o     = q.d_o;
  assign fourth_port_oe_o  = q.d_oe;
  assign sio_sck_in_o      = pins_s[12];
  assign sio_si_o          = pins_s[14];
  assign timer_match_pin_o = q.tmo;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_first_latch_wr: assert property (
    dm_wr_i && dm_at(`FNP_DM_FIRST) |=> ##1 first_port_o == $past(dm_wdata_i, 2))
    else $error("first port latch write not seen on pins");

  chk_first_dir_oe: assert property (
    rf_wr_i && rf_at(`FNP_RF_DIR_A) |=> ##1 first_port_oe_o == $past(rf_wdata_i, 2))
    else $error("first port direction not applied");

  chk_first_read_mix: assert property (
    dm_rd_i && dm_at(`FNP_DM_FIRST) |=> dm_rdata_o ==
      (($past(q.dir_a) & $past(q.lat_a)) | (~$past(q.dir_a) & $past(pins_s[3:0]))))
    else $error("first port read mix wrong");

  chk_second_group: assert property (
    second_port_oe_o == 4'h0 || second_port_oe_o == 4'hf)
    else $error("second port pins not switched together");

  chk_second_read: assert property (
    dm_rd_i && dm_at(`FNP_DM_SECOND) |=>
      dm_rdata_o == ($past(q.dir_b) ? $past(q.lat_b) : $past(pins_s[7:4])))
    else $error("second port read wrong");

  chk_third_read: assert property (
    dm_rd_i && dm_at(`FNP_DM_THIRD) |=> dm_rdata_o ==
      (($past(q.dir_c) & $past(q.lat_c)) | (~$past(q.dir_c) & $past(pins_s[11:8]))))
    else $error("third port read mix wrong");

  chk_third_no_drive: assert property (
    $past(q.dir_c) == 4'h0 |-> third_port_oe_o == 4'h0)
    else $error("input pin still driven");

  chk_fourth_low_only: assert property (
    fourth_port_o == 4'h0)
    else $error("open drain pin driven high");

  chk_fourth_latch_keep: assert property (
    rf_wr_i && rf_at(`FNP_RF_DIR_D) && !(dm_wr_i && dm_at(`FNP_DM_FOURTH))
      |=> q.lat_d == $past(q.lat_d))
    else $error("direction change altered latch");

  chk_serial_si_free: assert property (
    $past(q.sio_en) |-> !fourth_port_oe_o[2])
    else $error("serial input pin driven");

  chk_tmo_reset_one: assert property (
    timer_reset_i && q.tmo_sel && !rf_wr_i |=> !fourth_port_oe_o[3] && q.tmo)
    else $error("timer output not one after reset");

  chk_tmo_toggle: assert property (
    timer_match_i && !timer_reset_i |=> q.tmo != $past(q.tmo))
    else $error("timer output did not invert");

  cov_first_mixed: cover property (
    dm_rd_i && dm_at(`FNP_DM_FIRST) && q.dir_a == 4'h5);
  cov_serial_on: cover property (
    q.sio_en && sio_int_clk_i && dm_rd_i && dm_at(`FNP_DM_FOURTH));
  cov_tmo_toggles: cover property (
    q.tmo_sel && timer_match_i ##3 timer_match_i);
endmodule

// ==== testbench/fnp_board.sv ====
// Purpose: Board model for the pins of the four nibble ports
// Assumes: Every fourth-port pin has a pull-up; board levels come from the bench
// Notes:   A pin that the block drives shows the block's level, else the board's
`timescale 1ns/10ps
module fnp_board (
  input  wire fnp_pkg::fnp_nib_t a_o_i,        // First port drive value
  input  wire fnp_pkg::fnp_nib_t a_oe_i,       // First port drive enable
  input  wire fnp_pkg::fnp_nib_t b_o_i,        // Second port drive value
  input  wire fnp_pkg::fnp_nib_t b_oe_i,       // Second port drive enable
  input  wire fnp_pkg::fnp_nib_t c_o_i,        // Third port drive value
  input  wire fnp_pkg::fnp_nib_t c_oe_i,       // Third port drive enable
  input  wire fnp_pkg::fnp_nib_t d_oe_i,       // Fourth port pull-low enable
  input  wire fnp_pkg::fnp_nib_t ext_a_i,      // Board levels on released pins
  input  wire fnp_pkg::fnp_nib_t ext_b_i,
  input  wire fnp_pkg::fnp_nib_t ext_c_i,
  input  wire fnp_pkg::fnp_nib_t ext_d_i,      // 1 = left to pull-up, 0 = pulled low
  output fnp_pkg::fnp_nib_t      a_pin_o,      // Resolved wire levels
  output fnp_pkg::fnp_nib_t      b_pin_o,
  output fnp_pkg::fnp_nib_t      c_pin_o,
  output fnp_pkg::fnp_nib_t      d_pin_o
);
  import fnp_pkg::*;

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  // Push-pull: a driven pin follows the block, a released one the board
  assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & ext_a_i);
  assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & ext_b_i);
  assign c_pin_o = (c_oe_i & c_o_i) | (~c_oe_i & ext_c_i);
  // Open drain: only a low is ever forced; the pull-up never fights it
  assign d_pin_o = ~d_oe_i & ext_d_i;
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the four nibble I/O ports
// Assumes: Reads answer one clock after the strobe; pins settle in two flops
// Notes:   Reads are noted in queues and checked by a separate watcher
`timescale 1ns/10ps
`include "fnp_defs.svh"
module tb_top;
  import fnp_pkg::*;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [3:0] dm_bank_i = 4'h0;
  logic [6:0] dm_addr_i = 7'h00;
  logic [6:0] rf_addr_i = 7'h00;
  logic       dm_wr_i = 1'b0;
  logic       dm_rd_i = 1'b0;
  logic       rf_wr_i = 1'b0;
  logic       rf_rd_i = 1'b0;
  fnp_nib_t   dm_wdata_i = 4'h0;
  fnp_nib_t   rf_wdata_i = 4'h0;
  fnp_nib_t   dm_rdata_o;
  fnp_nib_t   rf_rdata_o;
  fnp_nib_t   ext [4] = '{default: 4'hf}; // Board levels
  fnp_nib_t   po [4];                     // Drive values
  fnp_nib_t   poe [4];                    // Drive enables
  fnp_nib_t   pin [4];                    // Resolved wires
  logic       sio_int_clk_i = 1'b0;
  logic       sio_sck_out_i = 1'b0;
  logic       sio_so_i = 1'b0;
  logic       timer_reset_i = 1'b0;
  logic       timer_match_i = 1'b0;
  logic       sio_sck_in_o;
  logic       sio_si_o;
  logic       timer_match_pin_o;
  int         err_total = 0;
  int         n_tests = 0;
  int         seed = 32'h60715c18;
  fnp_nib_t   dq [$];                     // Expected data memory reads
  fnp_nib_t   rq [$];                     // Expected register file reads
  logic       dm_rd_q = 1'b0;
  logic       rf_rd_q = 1'b0;
  localparam logic [6:0] DM_ADDR [4] = '{`FNP_DM_FIRST, `FNP_DM_SECOND, `FNP_DM_THIRD, `FNP_DM_FOURTH};
  localparam logic [6:0] DIR_ADDR [4] = '{`FNP_RF_DIR_A, `FNP_RF_DIR_B, `FNP_RF_DIR_C, `FNP_RF_DIR_D};

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Design and board
  // ----------------------------------------
  fnp_ports i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .dm_bank_i(dm_bank_i), .dm_addr_i(dm_addr_i),
    .dm_wr_i(dm_wr_i), .dm_rd_i(dm_rd_i), .dm_wdata_i(dm_wdata_i), .dm_rdata_o(dm_rdata_o),
    .rf_addr_i(rf_addr_i), .rf_wr_i(rf_wr_i), .rf_rd_i(rf_rd_i), .rf_wdata_i(rf_wdata_i),
    .rf_rdata_o(rf_rdata_o), .first_port_i(pin[0]), .first_port_o(po[0]), .first_port_oe_o(poe[0]),
    .second_port_i(pin[1]), .second_port_o(po[1]), .second_port_oe_o(poe[1]),
    .third_port_i(pin[2]), .third_port_o(po[2]), .third_port_oe_o(poe[2]),
    .fourth_port_i(pin[3]), .fourth_port_o(po[3]), .fourth_port_oe_o(poe[3]),
    .sio_int_clk_i(sio_int_clk_i), .sio_sck_out_i(sio_sck_out_i), .sio_so_i(sio_so_i),
    .sio_sck_in_o(sio_sck_in_o), .sio_si_o(sio_si_o), .timer_reset_i(timer_reset_i),
    .timer_match_i(timer_match_i), .timer_match_pin_o(timer_match_pin_o));

  fnp_board i_board (
    .a_o_i(po[0]), .a_oe_i(poe[0]), .b_o_i(po[1]), .b_oe_i(poe[1]), .c_o_i(po[2]),
    .c_oe_i(poe[2]), .d_oe_i(poe[3]), .ext_a_i(ext[0]), .ext_b_i(ext[1]), .ext_c_i(ext[2]),
    .ext_d_i(ext[3]), .a_pin_o(pin[0]), .b_pin_o(pin[1]), .c_pin_o(pin[2]), .d_pin_o(pin[3]));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input fnp_nib_t exp, input fnp_nib_t got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One access on either bus; an idle edge follows so strobes never double up
  task automatic acc(input bit rf, input logic [6:0] a, input logic wr, input fnp_nib_t d,
                     input fnp_nib_t exp, input logic [3:0] bank = 4'h0);
    if (rf) begin
      rf_addr_i <= a;
      rf_wdata_i <= d;
      rf_wr_i <= wr;
      rf_rd_i <= ~wr;
      if (!wr) rq.push_back(exp);
    end else begin
      dm_bank_i <= bank;
      dm_addr_i <= a;
      dm_wdata_i <= d;
      dm_wr_i <= wr;
      dm_rd_i <= ~wr;
      if (!wr) dq.push_back(exp);
    end
    @(posedge clk_i);
    {rf_wr_i, rf_rd_i, dm_wr_i, dm_rd_i} <= 4'h0;
    @(posedge clk_i);
  endtask

  // Answers are one clock late; look at them mid-cycle when settled
  always @(posedge clk_i) begin
    dm_rd_q <= dm_rd_i;
    rf_rd_q <= rf_rd_i;
  end
  always @(negedge clk_i) begin
    if (dm_rd_q) chk("dm read", dq.pop_front(), dm_rdata_o);
    if (rf_rd_q) chk("rf read", rq.pop_front(), rf_rdata_o);
  end

  // Watchdog, far beyond the expected run of about 430 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fnp_nib_t dir [4];
    fnp_nib_t lat [4];
    fnp_nib_t de;
    logic     tm;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (ext[p]) ext[p] <= 4'($random(seed));
    repeat (4) @(posedge clk_i);
    // Reset state: everything input, latches clear, timer pin high
    chk("timer pin", 4'h1, {3'b0, timer_match_pin_o});
    for (int p = 0; p < 4; p++) begin
      chk("oe after reset", 4'h0, poe[p]);
      acc(1, DIR_ADDR[p], 0, 4'h0, 4'h0);
      acc(0, DM_ADDR[p], 0, 4'h0, ext[p]);
    end
    // Random directions, latches and board levels
    for (int n = 0; n < 8; n++) begin
      for (int p = 0; p < 4; p++) begin
        dir[p] = 4'($random(seed));
        lat[p] = 4'($random(seed));
        ext[p] <= 4'($random(seed));
        acc(1, DIR_ADDR[p], 1, dir[p], 4'h0);
        acc(0, DM_ADDR[p], 1, lat[p], 4'h0);
      end
      repeat (4) @(posedge clk_i);
      for (int p = 0; p < 4; p++) begin
        de = (p == 1) ? {4{dir[1][0]}} : dir[p];
        chk("oe", (p == 3) ? (de & ~lat[p]) : de, poe[p]);
        chk("drive", (p < 3) ? lat[p] : 4'h0, po[p]);
        acc(0, DM_ADDR[p], 0, 4'h0, (de & lat[p]) | (~de & ext[p]));
        acc(1, DIR_ADDR[p], 0, 4'h0, (p == 1) ? {3'b0, dir[1][0]} : dir[p]);
      end
      // Output to input and back leaves the latch alone
      acc(1, DIR_ADDR[3], 1, 4'h0, 4'h0);
      acc(1, DIR_ADDR[3], 1, 4'hf, 4'h0);
      acc(0, DM_ADDR[3], 0, 4'h0, lat[3]);
    end
    // Other bank and unmapped register file place are ignored
    acc(0, DM_ADDR[0], 1, ~lat[0], 4'h0, 4'h1);
    acc(0, DM_ADDR[0], 0, 4'h0, 4'h0, 4'h1);
    acc(0, DM_ADDR[0], 0, 4'h0, (dir[0] & lat[0]) | (~dir[0] & ext[0]));
    acc(1, 7'h20, 0, 4'h0, 4'h0);
    // Serial pins, internal and external clock
    acc(1, DIR_ADDR[3], 1, 4'h0, 4'h0);
    acc(1, `FNP_RF_SIO_EN, 1, 4'h1, 4'h0);
    for (int j = 0; j < 4; j++) begin
      sio_int_clk_i <= j[0];
      sio_sck_out_i <= j[1];
      sio_so_i <= 1'($random(seed));
      ext[3] <= 4'($random(seed));
      repeat (4) @(posedge clk_i);
      chk("serial oe", {2'b00, ~sio_so_i, j[0] & ~j[1]}, poe[3]);
      chk("serial clock in", {3'b0, (j[0] & ~j[1]) ? 1'b0 : ext[3][0]}, {3'b0, sio_sck_in_o});
      chk("serial in", {3'b0, ext[3][2]}, {3'b0, sio_si_o});
      acc(0, DM_ADDR[3], 0, 4'h0, {ext[3][3:2], lat[3][1], j[0] ? lat[3][0] : ext[3][0]});
    end
    acc(1, `FNP_RF_SIO_EN, 0, 4'h0, 4'h1);
    acc(1, `FNP_RF_SIO_EN, 1, 4'h0, 4'h0);
    // Timer output on pin 3
    acc(1, `FNP_RF_TMO_SEL, 1, 4'h1, 4'h0);
    acc(1, DIR_ADDR[3], 1, 4'hf, 4'h0);
    acc(0, DM_ADDR[3], 1, 4'h8, 4'h0);
    // One match first, so the timer reset has a low flop to bring back to one
    timer_match_i <= 1'b1;
    @(posedge clk_i);
    timer_match_i <= 1'b0;
    timer_reset_i <= 1'b1;
    @(posedge clk_i);
    timer_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    tm = 1'b1;
    for (int k = 0; k < 4; k++) begin
      chk("timer pin", {3'b0, tm}, {3'b0, timer_match_pin_o});
      chk("timer oe", {~tm, 3'b111}, poe[3]);
      timer_match_i <= 1'b1;
      @(posedge clk_i);
      timer_match_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      tm = ~tm;
    end
    acc(0, DM_ADDR[3], 0, 4'h0, 4'h8);
    acc(1, `FNP_RF_TMO_SEL, 0, 4'h0, 4'h1);
    repeat (4) @(posedge clk_i);
    tally_and_finish();
  end
endmodule
